/* File: inc/ppmm_pkg.sv */
// shared constants and types for the pixel port mux mode block
package ppmm_pkg;

  localparam int BUS_W      = 32;
  localparam int REG_AW     = 8;
  localparam int REG_DW     = 32;
  localparam int FIFO_DEPTH = 16;
  localparam int DIV_W      = 8;

  // register byte addresses
  localparam logic [7:0] ADDR_FIRST  = 8'h00;
  localparam logic [7:0] ADDR_SECOND = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_PIXDIV = 8'h0C;
  localparam logic [7:0] ADDR_MODE   = 8'h10;

  // reset values: 24-bit direct color on a 32-bit bus
  localparam logic [7:0]       FIRST_RST  = 8'h06;
  localparam logic [7:0]       SECOND_RST = 8'h1B;
  localparam logic [DIV_W-1:0] PIXDIV_RST = 8'h00;

  // first control register codes
  localparam logic [7:0] MC1_DIR_888     = 8'h06;
  localparam logic [7:0] MC1_DIR_888_REV = 8'h07;
  localparam logic [7:0] MC1_DIR_565     = 8'h05;
  localparam logic [7:0] MC1_DIR_555     = 8'h04;
  localparam logic [7:0] MC1_DIR_664     = 8'h03;
  localparam logic [7:0] MC1_DIR_444     = 8'h01;
  localparam logic [7:0] MC1_TC_888      = 8'h46;
  localparam logic [7:0] MC1_TC_888_REV  = 8'h47;
  localparam logic [7:0] MC1_TC_565      = 8'h45;
  localparam logic [7:0] MC1_TC_555      = 8'h44;
  localparam logic [7:0] MC1_TC_664      = 8'h43;
  localparam logic [7:0] MC1_TC_444      = 8'h41;

  // second control register codes, legacy enable bit masked off
  localparam logic [6:0] MC2_BUS32_888   = 7'h1B;
  localparam logic [6:0] MC2_BUS16       = 7'h02;
  localparam logic [6:0] MC2_BUS32       = 7'h03;
  localparam logic [6:0] MC2_BUS16_444   = 7'h12;
  localparam logic [6:0] MC2_BUS32_444   = 7'h13;
  localparam int         LEGACY_EN_BIT   = 7;

  // status bits, write one to clear
  localparam int ST_CFG_ERR  = 0;
  localparam int ST_OVERFLOW = 1;

  // overlay bits per pixel
  localparam logic [3:0] OVL_NONE = 4'h0;
  localparam logic [3:0] OVL_555  = 4'h1;
  localparam logic [3:0] OVL_444  = 4'h4;
  localparam logic [3:0] OVL_888  = 4'h8;

  typedef enum logic [2:0] {
    FMT_888,
    FMT_565,
    FMT_555,
    FMT_664,
    FMT_444
  } ppmm_fmt_t;

  // fifo entry: fmt, true color, reversed, 32-bit bus, bus word
  localparam int ENTRY_W = 3 + 1 + 1 + 1 + BUS_W;

endpackage

/* File: hw/ppmm_fifo.sv */
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
module ppmm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  wire              full;
  wire              empty;
  wire              do_wr;
  wire              do_rd;

  assign full      = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty     = (wr_ptr == rd_ptr);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign do_wr     = in_valid && !full;
  assign do_rd     = out_ready && !empty;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge sys_clk) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

/* File: hw/ppmm_mode_dec.sv */
// decodes the two mux control values into a pixel port mode
`timescale 1ns/1ns
module ppmm_mode_dec
  import ppmm_pkg::*;
(
  input  wire logic [7:0] first,
  input  wire logic [7:0] second,
  output logic            mode_ok,
  output ppmm_fmt_t       fmt,
  output logic            true_color,
  output logic            reversed,
  output logic            bus32,
  output logic [3:0]      ovl_bits
);
  wire [6:0] lo;
  wire       w16;
  wire       w16_444;
  wire       is_888;
  wire       is_565;
  wire       is_555;
  wire       is_664;
  wire       is_444;

  // bit 7 only gates the legacy port, so mode decode ignores it
  assign lo      = second[6:0];
  assign w16     = (lo == MC2_BUS16) || (lo == MC2_BUS32);
  assign w16_444 = (lo == MC2_BUS16_444) || (lo == MC2_BUS32_444);

  assign is_888 = (((first == MC1_DIR_888) || (first == MC1_DIR_888_REV))
                   && (lo == MC2_BUS32_888))
               || (((first == MC1_TC_888) || (first == MC1_TC_888_REV))
                   && (lo == MC2_BUS32));
  assign is_565 = ((first == MC1_DIR_565) || (first == MC1_TC_565)) && w16;
  assign is_555 = ((first == MC1_DIR_555) || (first == MC1_TC_555)) && w16;
  assign is_664 = ((first == MC1_DIR_664) || (first == MC1_TC_664)) && w16;
  assign is_444 = ((first == MC1_DIR_444) && w16_444)
               || ((first == MC1_TC_444) && w16);

  assign mode_ok    = is_888 || is_565 || is_555 || is_664 || is_444;
  assign fmt        = is_888 ? FMT_888 : is_565 ? FMT_565 : is_555 ? FMT_555 :
                      is_664 ? FMT_664 : FMT_444;
  assign true_color = first[6];
  assign reversed   = (first == MC1_DIR_888_REV) || (first == MC1_TC_888_REV);
  assign bus32      = is_888 || lo[0];
  assign ovl_bits   = true_color ? OVL_NONE : is_888 ? OVL_888 :
                      is_555 ? OVL_555 : is_444 ? OVL_444 : OVL_NONE;
endmodule

/* File: hw/ppmm_top.sv */
// pixel port input multiplexer: mode registers, load latching, pixel shift-out
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ns
module ppmm_top
  import ppmm_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic [REG_AW-1:0] reg_addr,
  input  wire logic [REG_DW-1:0] reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic      [REG_DW-1:0] reg_rdata,
  input  wire logic [BUS_W-1:0]  pixel_bus,
  input  wire logic              pixel_load_strobe,
  input  wire logic              pixel_ready,
  output logic                   pixel_valid,
  output logic      [7:0]        pixel_red,
  output logic      [7:0]        pixel_green,
  output logic      [7:0]        pixel_blue,
  output logic      [7:0]        pixel_overlay,
  output logic                   pixel_true_color,
  output logic                   legacy_port_en,
  output logic                   config_error
);

  ////////////////////////////////////////////////////////////////////////////
  // register port

  logic [7:0]       mux_control_first;
  logic [7:0]       mux_control_second;
  logic [DIV_W-1:0] pixel_div;
  logic             sticky_cfg_err;
  logic             sticky_overflow;

  ppmm_fmt_t        act_fmt;
  logic             act_true;
  logic             act_rev;
  logic             act_bus32;
  logic [3:0]       act_ovl;

  wire              wr_first;
  wire              wr_second;
  wire              wr_status;
  wire              wr_pixdiv;
  wire              wr_ctrl;
  wire [7:0]        cand_first;
  wire [7:0]        cand_second;

  wire              dec_ok;
  ppmm_fmt_t        dec_fmt;
  wire              dec_true;
  wire              dec_rev;
  wire              dec_bus32;
  wire [3:0]        dec_ovl;

  wire              set_cfg_err;
  wire              set_overflow;
  wire              clr_cfg_err;
  wire              clr_overflow;
  logic [REG_DW-1:0] rd_value;

  assign wr_first    = reg_write && (reg_addr == ADDR_FIRST);
  assign wr_second   = reg_write && (reg_addr == ADDR_SECOND);
  assign wr_status   = reg_write && (reg_addr == ADDR_STATUS);
  assign wr_pixdiv   = reg_write && (reg_addr == ADDR_PIXDIV);
  assign wr_ctrl     = wr_first || wr_second;

  // the mode is judged on the pair as it will stand after this write
  assign cand_first  = wr_first ? reg_wdata[7:0] : mux_control_first;
  assign cand_second = wr_second ? reg_wdata[7:0] : mux_control_second;

  ppmm_mode_dec u_dec (
    .first      (cand_first),
    .second     (cand_second),
    .mode_ok    (dec_ok),
    .fmt        (dec_fmt),
    .true_color (dec_true),
    .reversed   (dec_rev),
    .bus32      (dec_bus32),
    .ovl_bits   (dec_ovl)
  );

  assign set_cfg_err  = wr_ctrl && !dec_ok;
  assign clr_cfg_err  = wr_status && reg_wdata[ST_CFG_ERR];
  assign clr_overflow = wr_status && reg_wdata[ST_OVERFLOW];

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      mux_control_first  <= FIRST_RST;
      mux_control_second <= SECOND_RST;
      pixel_div          <= PIXDIV_RST;
    end else begin
      if (wr_first) begin
        mux_control_first <= reg_wdata[7:0];
      end
      if (wr_second) begin
        mux_control_second <= reg_wdata[7:0];
      end
      if (wr_pixdiv) begin
        pixel_div <= reg_wdata[DIV_W-1:0];
      end
    end
  end

  // an unsupported pair leaves the running mode untouched
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      act_fmt   <= FMT_888;
      act_true  <= 1'b0;
      act_rev   <= 1'b0;
      act_bus32 <= 1'b1;
      act_ovl   <= OVL_888;
    end else if (wr_ctrl && dec_ok) begin
      act_fmt   <= dec_fmt;
      act_true  <= dec_true;
      act_rev   <= dec_rev;
      act_bus32 <= dec_bus32;
      act_ovl   <= dec_ovl;
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sticky_cfg_err  <= 1'b0;
      sticky_overflow <= 1'b0;
    end else begin
      sticky_cfg_err  <= set_cfg_err || (sticky_cfg_err && !clr_cfg_err);
      sticky_overflow <= set_overflow || (sticky_overflow && !clr_overflow);
    end
  end

  always_comb begin
    rd_value = '0;
    if (reg_addr == ADDR_FIRST) begin
      rd_value[7:0] = mux_control_first;
    end else if (reg_addr == ADDR_SECOND) begin
      rd_value[7:0] = mux_control_second;
    end else if (reg_addr == ADDR_STATUS) begin
      rd_value[ST_CFG_ERR]  = sticky_cfg_err;
      rd_value[ST_OVERFLOW] = sticky_overflow;
    end else if (reg_addr == ADDR_PIXDIV) begin
      rd_value[DIV_W-1:0] = pixel_div;
    end else if (reg_addr == ADDR_MODE) begin
      rd_value[9:0] = {act_ovl, act_bus32, act_rev, act_true, act_fmt};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_read ? rd_value : '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      legacy_port_en <= 1'b0;
      config_error   <= 1'b0;
    end else begin
      legacy_port_en <= mux_control_second[LEGACY_EN_BIT];
      config_error   <= sticky_cfg_err;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and load latching

  logic [BUS_W-1:0] bus_s1;
  logic [BUS_W-1:0] bus_s2;
  logic             strobe_s1;
  logic             strobe_s2;
  logic             strobe_s3;
  wire              load_edge;
  wire              fifo_in_ready;
  wire [ENTRY_W-1:0] fifo_in_data;

  // bus must hold steady a few cycles around the strobe edge
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      bus_s1    <= '0;
      bus_s2    <= '0;
      strobe_s1 <= 1'b0;
      strobe_s2 <= 1'b0;
      strobe_s3 <= 1'b0;
    end else begin
      bus_s1    <= pixel_bus;
      bus_s2    <= bus_s1;
      strobe_s1 <= pixel_load_strobe;
      strobe_s2 <= strobe_s1;
      strobe_s3 <= strobe_s2;
    end
  end

  assign load_edge    = strobe_s2 && !strobe_s3;
  // the whole bus word is latched once; the ratio travels with it
  assign fifo_in_data = {act_fmt, act_true, act_rev, act_bus32, bus_s2};
  // no pin to stall the controller, so a load into a full fifo is lost
  assign set_overflow = load_edge && !fifo_in_ready;

  ////////////////////////////////////////////////////////////////////////////
  // load buffer

  wire               fifo_out_valid;
  wire               fifo_out_ready;
  wire [ENTRY_W-1:0] fifo_out_data;

  ppmm_fifo #(
    .WIDTH (ENTRY_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .in_valid  (load_edge),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pixel rate and shift-out

  logic [DIV_W-1:0]   div_cnt;
  wire                pix_tick;
  logic [ENTRY_W-1:0] sh_word;
  logic               sh_busy;
  logic               sh_grp;
  wire                sh_fire;
  wire                sh_two;
  wire                sh_last;
  ppmm_fmt_t          sh_fmt;
  wire                sh_true;
  wire                sh_rev;
  wire                sh_bus32;
  wire [31:0]         sh_pix;

  assign pix_tick = (div_cnt == pixel_div);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= pix_tick ? '0 : div_cnt + 1'b1;
    end
  end

  assign sh_fmt         = ppmm_fmt_t'(sh_word[ENTRY_W-1 -: 3]);
  assign sh_true        = sh_word[BUS_W+2];
  assign sh_rev         = sh_word[BUS_W+1];
  assign sh_bus32       = sh_word[BUS_W];
  assign sh_two         = sh_bus32 && (sh_fmt != FMT_888);
  assign sh_fire        = sh_busy && pix_tick && pixel_ready;
  assign sh_last        = !sh_two || sh_grp;
  assign fifo_out_ready = !sh_busy;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sh_word <= '0;
      sh_busy <= 1'b0;
      sh_grp  <= 1'b0;
    end else if (!sh_busy) begin
      if (fifo_out_valid) begin
        sh_word <= fifo_out_data;
        sh_busy <= 1'b1;
        sh_grp  <= 1'b0;
      end
    end else if (sh_fire) begin
      sh_grp  <= !sh_last;
      sh_busy <= !sh_last;
    end
  end

  // unpack one pixel group into overlay, red, green, blue (colours msb aligned, overlay right aligned)
  function automatic logic [31:0] unpack(input ppmm_fmt_t fmt, input logic rev,
                                         input logic tc, input logic [31:0] w,
                                         input logic grp);
    logic [15:0] h;
    logic [7:0]  o;
    logic [7:0]  r;
    logic [7:0]  g;
    logic [7:0]  b;
    h = grp ? w[31:16] : w[15:0];
    o = 8'h00;
    r = 8'h00;
    g = 8'h00;
    b = 8'h00;
    case (fmt)
      FMT_888: begin
        if (rev) begin
          b = w[31:24];
          g = w[23:16];
          r = w[15:8];
          o = w[7:0];
        end else begin
          o = w[31:24];
          r = w[23:16];
          g = w[15:8];
          b = w[7:0];
        end
      end
      FMT_565: begin
        r = {h[15:11], 3'h0};
        g = {h[10:5], 2'h0};
        b = {h[4:0], 3'h0};
      end
      FMT_555: begin
        o = {7'h00, h[15]};
        r = {h[14:10], 3'h0};
        g = {h[9:5], 3'h0};
        b = {h[4:0], 3'h0};
      end
      FMT_664: begin
        r = {h[15:10], 2'h0};
        g = {h[9:4], 2'h0};
        b = {h[3:0], 4'h0};
      end
      default: begin
        r = {h[15:12], 4'h0};
        g = {h[11:8], 4'h0};
        b = {h[7:4], 4'h0};
        o = {4'h0, h[3:0]};
      end
    endcase
    // true color modes carry no overlay
    if (tc) begin
      o = 8'h00;
    end
    return {o, r, g, b};
  endfunction

  assign sh_pix = unpack(sh_fmt, sh_rev, sh_true, sh_word[BUS_W-1:0], sh_grp);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pixel_valid      <= 1'b0;
      pixel_overlay    <= 8'h00;
      pixel_red        <= 8'h00;
      pixel_green      <= 8'h00;
      pixel_blue       <= 8'h00;
      pixel_true_color <= 1'b0;
    end else begin
      pixel_valid <= sh_fire;
      if (sh_fire) begin
        pixel_overlay    <= sh_pix[31:24];
        pixel_red        <= sh_pix[23:16];
        pixel_green      <= sh_pix[15:8];
        pixel_blue       <= sh_pix[7:0];
        pixel_true_color <= sh_true;
      end
    end
  end

endmodule

/* File: testbench/ppmm_props.sv */
// assertions on the ports of the pixel port mux mode top
`timescale 1ns/1ns
module ppmm_props
  import ppmm_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              resetn,
  input wire logic [REG_AW-1:0] reg_addr,
  input wire logic [REG_DW-1:0] reg_wdata,
  input wire logic              reg_write,
  input wire logic              reg_read,
  input wire logic [REG_DW-1:0] reg_rdata,
  input wire logic [BUS_W-1:0]  pixel_bus,
  input wire logic              pixel_load_strobe,
  input wire logic              pixel_ready,
  input wire logic              pixel_valid,
  input wire logic [7:0]        pixel_red,
  input wire logic [7:0]        pixel_green,
  input wire logic [7:0]        pixel_blue,
  input wire logic [7:0]        pixel_overlay,
  input wire logic              pixel_true_color,
  input wire logic              legacy_port_en,
  input wire logic              config_error
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  wire sec_wr = reg_write && reg_addr == ADDR_SECOND;
  wire clr_wr = reg_write && reg_addr == ADDR_STATUS && reg_wdata[ST_CFG_ERR];
  // code 02 is unlisted whatever the second register holds
  wire bad_wr = reg_write && reg_addr == ADDR_FIRST && reg_wdata[7:0] == 8'h02;

  AST_RDATA_IDLE: assert property (!$past(reg_read) |-> reg_rdata == '0)
    else $error("read data not zero outside a read answer");
  AST_LEGACY_FOLLOW: assert property (
    sec_wr |-> ##2 legacy_port_en == $past(reg_wdata[LEGACY_EN_BIT], 2))
    else $error("legacy enable does not follow second register bit 7");
  AST_READ_SECOND: assert property (
    reg_read && reg_addr == ADDR_SECOND |=>
      reg_rdata[7] == legacy_port_en && reg_rdata[31:8] == '0)
    else $error("second register readback disagrees with legacy enable");
  AST_BAD_FLAGS: assert property (bad_wr |-> ##2 config_error)
    else $error("unlisted mode code did not flag an error");
  AST_ERR_STICKY: assert property (
    config_error && !clr_wr && !$past(clr_wr) |=> config_error)
    else $error("config error dropped without a clear");
  AST_ERR_CLEARS: assert property (clr_wr |-> ##2 !config_error)
    else $error("config error not cleared by write one");
  AST_VALID_READY: assert property (pixel_valid |-> $past(pixel_ready))
    else $error("pixel sent while downstream not ready");
  AST_OVL_TRUE: assert property (
    pixel_valid && pixel_true_color |-> pixel_overlay == 8'h00)
    else $error("true color pixel carries overlay");
  AST_MODE_READ: assert property (
    reg_read && reg_addr == ADDR_MODE |=>
      reg_rdata[2:0] <= 3'h4 && reg_rdata[31:10] == '0)
    else $error("active mode word out of range");

  cover property (pixel_valid && pixel_true_color);
  cover property (pixel_valid && pixel_overlay != 8'h00);
  cover property ($rose(config_error));
endmodule

bind ppmm_top ppmm_props chk_u (
  .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .pixel_bus(pixel_bus), .pixel_load_strobe(pixel_load_strobe),
  .pixel_ready(pixel_ready), .pixel_valid(pixel_valid), .pixel_red(pixel_red),
  .pixel_green(pixel_green), .pixel_blue(pixel_blue), .pixel_overlay(pixel_overlay),
  .pixel_true_color(pixel_true_color), .legacy_port_en(legacy_port_en),
  .config_error(config_error)
);

/* File: testbench/ppmm_gfx_model.sv */
// graphics controller model: drives the pixel bus and the load strobe
`timescale 1ns/1ns
module ppmm_gfx_model
  import ppmm_pkg::*;
(
  input  wire logic             sys_clk,
  output logic      [BUS_W-1:0] pixel_bus,
  output logic                  pixel_load_strobe
);
  initial begin
    pixel_bus = '0;
    pixel_load_strobe = 1'b0;
  end
  // one load: word set up a cycle early, held three cycles past the rise
  task automatic send(input logic [BUS_W-1:0] word, input int gap);
    @(posedge sys_clk);
    pixel_bus <= word;
    @(posedge sys_clk);
    pixel_load_strobe <= 1'b1;
    repeat (2) @(posedge sys_clk);
    pixel_load_strobe <= 1'b0;
    @(posedge sys_clk);
    // released bus inverted so a late sample cannot match by luck
    pixel_bus <= ~word;
    repeat (gap) @(posedge sys_clk);
  endtask
endmodule

/* File: testbench/testbench.sv */
// self-checking bench for the pixel port mux mode block
`timescale 1ns/1ns
module testbench
  import ppmm_pkg::*;
;
  logic              sys_clk = 1'b0;
  logic              resetn;
  logic [REG_AW-1:0] reg_addr;
  logic [REG_DW-1:0] reg_wdata;
  logic              reg_write;
  logic              reg_read;
  logic [REG_DW-1:0] reg_rdata;
  logic [BUS_W-1:0]  pixel_bus;
  logic              pixel_load_strobe;
  logic              pixel_ready;
  logic              pixel_valid;
  logic [7:0]        pixel_red, pixel_green, pixel_blue, pixel_overlay;
  logic              pixel_true_color, legacy_port_en, config_error;
  int                fail_count = 0;
  int                checks = 0;
  int                n;
  logic [31:0]       w;
  logic [32:0]       pix_q[$];
  logic [7:0]        mode_f[20] = '{8'h06, 8'h07, 8'h05, 8'h05, 8'h04, 8'h04, 8'h03, 8'h03,
    8'h01, 8'h01, 8'h46, 8'h47, 8'h45, 8'h45, 8'h44, 8'h44, 8'h43, 8'h43, 8'h41, 8'h41};
  logic [7:0]        mode_s[20] = '{8'h1B, 8'h1B, 8'h02, 8'h03, 8'h02, 8'h03, 8'h02, 8'h03,
    8'h12, 8'h13, 8'h03, 8'h03, 8'h02, 8'h03, 8'h02, 8'h03, 8'h02, 8'h03, 8'h02, 8'h03};

  always #2 sys_clk = ~sys_clk;

  ppmm_top dut_u (
    .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .pixel_bus(pixel_bus), .pixel_load_strobe(pixel_load_strobe),
    .pixel_ready(pixel_ready), .pixel_valid(pixel_valid), .pixel_red(pixel_red),
    .pixel_green(pixel_green), .pixel_blue(pixel_blue), .pixel_overlay(pixel_overlay),
    .pixel_true_color(pixel_true_color), .legacy_port_en(legacy_port_en),
    .config_error(config_error));
  ppmm_gfx_model gfx_u (
    .sys_clk(sys_clk), .pixel_bus(pixel_bus), .pixel_load_strobe(pixel_load_strobe));

  always @(posedge sys_clk) begin
    if (pixel_valid === 1'b1) begin
      pix_q.push_back({pixel_true_color, pixel_overlay, pixel_red, pixel_green, pixel_blue});
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    @(negedge sys_clk);
    check(what, reg_rdata, exp);
  endtask
  task automatic wait_pix(input int cnt);
    for (int i = 0; i < 400 && pix_q.size() < cnt; i++) @(posedge sys_clk);
    if (pix_q.size() < cnt) begin
      fail_count++;
      $display("unexpected pixel count: expected %0d, seen %0d", cnt, pix_q.size());
      test_done();
    end
  endtask

  // active mode word: fmt, true, reversed, 32-bit bus, overlay bits
  function automatic logic [31:0] mode_word(input logic [7:0] f, input logic [7:0] s);
    logic [2:0] fm;
    logic [3:0] ov;
    fm = (f[2:0] == 3'h5) ? 3'h1 : (f[2:0] == 3'h4) ? 3'h2 : (f[2:0] == 3'h3) ? 3'h3 :
         (f[2:0] == 3'h1) ? 3'h4 : 3'h0;
    ov = f[6] ? 4'h0 : (fm == 3'h0) ? 4'h8 : (fm == 3'h2) ? 4'h1 : (fm == 3'h4) ? 4'h4 : 4'h0;
    return {22'h0, ov, s[0], f[2:0] == 3'h7, f[6], fm};
  endfunction
  // colours msb aligned, overlay right aligned; 16-bit formats use w[15:0]
  function automatic logic [32:0] exp_pix(input logic [7:0] f, input logic [31:0] w);
    logic [7:0] o, r, g, b;
    case (f[2:0])
      3'h6: {o, r, g, b} = w;
      3'h7: {b, g, r, o} = w;
      3'h5: {o, r, g, b} = {8'h0, w[15:11], 3'h0, w[10:5], 2'h0, w[4:0], 3'h0};
      3'h4: {o, r, g, b} = {7'h0, w[15], w[14:10], 3'h0, w[9:5], 3'h0, w[4:0], 3'h0};
      3'h3: {o, r, g, b} = {8'h0, w[15:10], 2'h0, w[9:4], 2'h0, w[3:0], 4'h0};
      default: {o, r, g, b} = {4'h0, w[3:0], w[15:12], 4'h0, w[11:8], 4'h0, w[7:4], 4'h0};
    endcase
    return {f[6], f[6] ? 8'h00 : o, r, g, b};
  endfunction
  task automatic chk_pix(input logic [7:0] f, input logic [31:0] word);
    check("pixel", pix_q.pop_front(), exp_pix(f, word));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    pixel_ready = 1'b1;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    rd_chk(ADDR_FIRST, 32'h06, "first");
    rd_chk(ADDR_SECOND, 32'h1B, "second");
    rd_chk(ADDR_STATUS, 32'h0, "status");
    rd_chk(ADDR_MODE, mode_word(8'h06, 8'h1B), "mode");
    check("legacy", legacy_port_en, 1'b0);
    reg_wr(ADDR_PIXDIV, 32'h3);
    rd_chk(ADDR_PIXDIV, 32'h3, "divider");
    $display("test reset done");
    // true color data kept symmetric so component order cannot matter
    for (int i = 0; i < 20; i++) begin
      reg_wr(ADDR_SECOND, {24'h0, mode_s[i]});
      reg_wr(ADDR_FIRST, {24'h0, mode_f[i]});
      reg_wr(ADDR_STATUS, 32'h3);
      rd_chk(ADDR_MODE, mode_word(mode_f[i], mode_s[i]), "mode");
      check("error", config_error, 1'b0);
      n = (mode_s[i][0] && mode_f[i][2:1] != 2'b11) ? 2 : 1;
      w = !mode_f[i][6] ? 32'hD6B34E9C : (mode_f[i][2:1] == 2'b11) ? 32'h00FFFF00 :
          mode_s[i][0] ? 32'hFFFF0000 : 32'h0000FFFF;
      gfx_u.send(w, 2);
      wait_pix(n);
      chk_pix(mode_f[i], w);
      if (n == 2) chk_pix(mode_f[i], w >> 16);
      repeat (6) @(posedge sys_clk);
      check("pixel count", pix_q.size(), 0);
    end
    $display("test modes done");
    reg_wr(ADDR_FIRST, 32'h06);
    reg_wr(ADDR_SECOND, 32'h9B);
    reg_wr(ADDR_STATUS, 32'h3);
    check("legacy", legacy_port_en, 1'b1);
    rd_chk(ADDR_SECOND, 32'h9B, "second");
    rd_chk(ADDR_MODE, mode_word(8'h06, 8'h1B), "mode");
    check("error", config_error, 1'b0);
    reg_wr(ADDR_SECOND, 32'h1B);
    repeat (2) @(posedge sys_clk);
    check("legacy", legacy_port_en, 1'b0);
    $display("test legacy done");
    reg_wr(ADDR_FIRST, 32'h46);
    reg_wr(8'h14, 32'hFF);
    check("error", config_error, 1'b1);
    rd_chk(ADDR_MODE, mode_word(8'h06, 8'h1B), "mode");
    rd_chk(ADDR_FIRST, 32'h46, "first");
    rd_chk(8'h14, 32'h0, "unmapped");
    reg_wr(ADDR_STATUS, 32'h1);
    reg_wr(ADDR_FIRST, 32'h02);
    gfx_u.send(32'hD6B34E9C, 2);
    wait_pix(1);
    chk_pix(8'h06, 32'hD6B34E9C);
    check("error", config_error, 1'b1);
    $display("test bad codes done");
    reg_wr(ADDR_SECOND, 32'h03);
    reg_wr(ADDR_FIRST, 32'h05);
    reg_wr(ADDR_STATUS, 32'h3);
    pixel_ready <= 1'b0;
    for (int k = 0; k < 20; k++) gfx_u.send({16'(2 * k + 1), 16'(2 * k)}, 0);
    rd_chk(ADDR_STATUS, 32'h2, "status");
    pixel_ready <= 1'b1;
    wait_pix(34);
    for (int k = 0; k < 34; k++) chk_pix(8'h05, 32'(k));
    repeat (60) @(posedge sys_clk);
    check("pixel count", pix_q.size(), 0);
    reg_wr(ADDR_STATUS, 32'h3);
    rd_chk(ADDR_STATUS, 32'h0, "status");
    $display("test fifo done");
    test_done();
  end
endmodule
